// ===== mra_pkg.sv
// Package of constants for the macrocell register array
package mra_pkg;
  localparam int NUM_CELLS = 10;
  localparam int NUM_INPUTS = 10;
  localparam int NUM_DATA_TERMS = 4;
  localparam logic POL_ACTIVE_LOW = 1'b0;
  localparam logic FF_RESET_VAL = 1'b0;
  localparam logic FF_PRESET_VAL = 1'b1;
  localparam logic PIN_ENABLE_LVL = 1'b0;
  localparam logic PRELOAD_LVL = 1'b0;
endpackage : mra_pkg

// ===== mra_output_macrocell.sv
// One output macrocell: flip-flop, polarity gate, bypass and output enable
`timescale 1ns/1ps
module mra_output_macrocell #(
  parameter int TERMS = mra_pkg::NUM_DATA_TERMS
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic clk_en,
  input wire logic [TERMS-1:0] data_terms,
  input wire logic polarity_bit,
  input wire logic clock_term,
  input wire logic reset_term,
  input wire logic preset_term,
  input wire logic oe_term,
  input wire logic oe_pin_n,
  input wire logic preload_n,
  input wire logic pin_level,
  output logic pin_out,
  output logic pin_oe,
  output logic ff_state
);
  logic ff_q;
  logic ff_d;
  logic clk_term_q;
  logic pin_out_q;
  logic pin_oe_q;
  wire sum_of_terms = |data_terms;
  // Erased bit inverts the node, so the pin follows the sum
  wire xor_node = sum_of_terms ^ polarity_bit;
  wire clk_rise = clock_term & ~clk_term_q;
  wire bypass = reset_term & preset_term;
  wire drive_en = oe_term & (oe_pin_n == mra_pkg::PIN_ENABLE_LVL);
  wire preload_on = (preload_n == mra_pkg::PRELOAD_LVL);
  wire preload_act = preload_on & ~drive_en;
  // Enabled cell keeps its state while preload is low
  wire preload_keep = preload_on & drive_en;
  // Low pin presets, high pin resets
  wire preload_val = pin_level ? mra_pkg::FF_RESET_VAL : mra_pkg::FF_PRESET_VAL;

  // Priority: preload, then level reset/preset, then clock edge
  always_comb
  begin
    ff_d = ff_q;
    if (preload_act)
    begin
      ff_d = preload_val;
    end
    else if (preload_keep || bypass)
    begin
      ff_d = ff_q;
    end
    else if (reset_term)
    begin
      ff_d = mra_pkg::FF_RESET_VAL;
    end
    else if (preset_term)
    begin
      ff_d = mra_pkg::FF_PRESET_VAL;
    end
    else if (clk_rise)
    begin
      ff_d = xor_node;
    end
  end

  // Inverting buffer, bypass gives combinatorial path
  wire out_node = bypass ? xor_node : ff_d;
  wire pin_out_d = ~out_node;

  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      ff_q <= mra_pkg::FF_RESET_VAL;
      clk_term_q <= 1'b0;
      pin_out_q <= 1'b1;
      pin_oe_q <= 1'b0;
    end
    else if (clk_en)
    begin
      ff_q <= ff_d;
      clk_term_q <= clock_term;
      pin_out_q <= pin_out_d;
      pin_oe_q <= drive_en;
    end
  end

  assign pin_out = pin_out_q;
  assign pin_oe = pin_oe_q;
  assign ff_state = ff_q;
endmodule : mra_output_macrocell

// ===== mra_macrocell_register_array.sv
// Top of the macrocell register array: pin synchronisers and ten macrocells
`timescale 1ns/1ps
module mra_macrocell_register_array #(
  parameter int CELLS = mra_pkg::NUM_CELLS,
  parameter int INPUTS = mra_pkg::NUM_INPUTS,
  parameter int TERMS = mra_pkg::NUM_DATA_TERMS
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic clk_en,
  input wire logic [INPUTS-1:0] in_pins,
  input wire logic [CELLS-1:0] io_in,
  output logic [CELLS-1:0] io_out,
  output logic [CELLS-1:0] io_oe,
  input wire logic oe_pin_n,
  input wire logic preload_n,
  input wire logic [CELLS*TERMS-1:0] data_terms,
  input wire logic [CELLS-1:0] polarity_bits,
  input wire logic [CELLS-1:0] clock_terms,
  input wire logic [CELLS-1:0] reset_terms,
  input wire logic [CELLS-1:0] preset_terms,
  input wire logic [CELLS-1:0] oe_terms,
  output logic [INPUTS-1:0] array_inputs,
  output logic [CELLS-1:0] array_io,
  output logic [CELLS-1:0] array_feedback
);
  localparam int SW = INPUTS + CELLS + 2;

  ////////////////////////////////////////////////////////////////////////////
  // Three-stage pin synchronisers, change accepted when stages two and three agree
  logic [SW-1:0] s1_q;
  logic [SW-1:0] s2_q;
  logic [SW-1:0] s3_q;
  logic [SW-1:0] pin_q;
  logic [INPUTS-1:0] array_inputs_q;
  logic [CELLS-1:0] array_io_q;
  logic [CELLS-1:0] fb_q;
  wire [SW-1:0] raw_pins = {preload_n, oe_pin_n, io_in, in_pins};
  wire [SW-1:0] agree = ~(s2_q ^ s3_q);
  wire [SW-1:0] pin_d = (agree & s3_q) | (~agree & pin_q);
  wire [SW-1:0] pin_reset = {2'b11, {(SW-2){1'b0}}};
  wire [CELLS-1:0] ff_state;
  wire [INPUTS-1:0] in_sync = pin_q[INPUTS-1:0];
  wire [CELLS-1:0] io_sync = pin_q[INPUTS+CELLS-1:INPUTS];
  wire oe_sync_n = pin_q[SW-2];
  wire preload_sync_n = pin_q[SW-1];

  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      s1_q <= pin_reset;
      s2_q <= pin_reset;
      s3_q <= pin_reset;
      pin_q <= pin_reset;
      array_inputs_q <= {INPUTS{1'b0}};
      array_io_q <= {CELLS{1'b0}};
      fb_q <= {CELLS{1'b0}};
    end
    else if (clk_en)
    begin
      s1_q <= raw_pins;
      s2_q <= s1_q;
      s3_q <= s2_q;
      pin_q <= pin_d;
      array_inputs_q <= in_sync;
      array_io_q <= io_sync;
      fb_q <= ff_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Identical macrocells, one per I/O pin
  genvar gi;
  generate
    for (gi = 0; gi < CELLS; gi++)
    begin : g_cell
      mra_output_macrocell #(
        .TERMS(TERMS)
      ) u_cell (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .clk_en(clk_en),
        .data_terms(data_terms[gi*TERMS +: TERMS]),
        .polarity_bit(polarity_bits[gi]),
        .clock_term(clock_terms[gi]),
        .reset_term(reset_terms[gi]),
        .preset_term(preset_terms[gi]),
        .oe_term(oe_terms[gi]),
        .oe_pin_n(oe_sync_n),
        .preload_n(preload_sync_n),
        .pin_level(io_sync[gi]),
        .pin_out(io_out[gi]),
        .pin_oe(io_oe[gi]),
        .ff_state(ff_state[gi])
      );
    end
  endgenerate

  assign array_inputs = array_inputs_q;
  assign array_io = array_io_q;
  assign array_feedback = fb_q;
endmodule : mra_macrocell_register_array

// ===== mra_array_properties.sv
// Checker for cell 0 of the macrocell register array
`timescale 1ns/1ps
module mra_array_properties #(
  parameter int CELLS = 10,
  parameter int TERMS = 4
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic clk_en,
  input wire logic [CELLS-1:0] io_in,
  input wire logic [CELLS-1:0] io_out,
  input wire logic [CELLS-1:0] io_oe,
  input wire logic oe_pin_n,
  input wire logic preload_n,
  input wire logic [CELLS*TERMS-1:0] data_terms,
  input wire logic [CELLS-1:0] polarity_bits,
  input wire logic [CELLS-1:0] clock_terms,
  input wire logic [CELLS-1:0] reset_terms,
  input wire logic [CELLS-1:0] preset_terms,
  input wire logic [CELLS-1:0] oe_terms,
  input wire logic [CELLS-1:0] array_feedback
);
  wire r0 = reset_terms[0];
  wire p0 = preset_terms[0];
  wire q0 = (|data_terms[TERMS-1:0]) ^ polarity_bits[0];
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst || !clk_en);
  sequence quiet;
    preload_n [*8];
  endsequence
  a_reset_high: assert property (quiet ##0 (r0 && !p0) |=> io_out[0])
    else $error("reset pin not high");
  a_bypass_comb: assert property (quiet ##0 (r0 && p0) |=> io_out[0] == !$past(q0))
    else $error("bypass value wrong");
  a_clock_capture: assert property (quiet ##0 ($past(clk_en) && $rose(clock_terms[0])
    && !r0 && !p0) |=> io_out[0] == !$past(q0)) else $error("captured value wrong");
  a_oe_term_off: assert property (!oe_terms[0] |=> !io_oe[0])
    else $error("enable without term");
  a_oe_pin_off: assert property (oe_pin_n [*8] |=> !io_oe[0])
    else $error("enable with pin high");
  a_preload_load: assert property ((!preload_n && !oe_terms[0] && !(r0 && p0)
    && $stable(io_in[0])) [*8] |=> io_out[0] == io_in[0]) else $error("preload value wrong");
  a_preload_keep: assert property ((!preload_n && oe_terms[0] && !oe_pin_n && !(r0 && p0))
    [*8] |=> $stable(io_out[0])) else $error("enabled cell preloaded");
  a_feedback_state: assert property (!(r0 && p0) |=> ##1
    array_feedback[0] == !$past(io_out[0])) else $error("feedback wrong");
endmodule : mra_array_properties
bind mra_macrocell_register_array mra_array_properties #(.CELLS(CELLS), .TERMS(TERMS))
  mra_array_properties_inst (.clk_sys, .nrst, .clk_en, .io_in, .io_out, .io_oe, .oe_pin_n, .preload_n,
  .data_terms, .polarity_bits, .clock_terms, .reset_terms, .preset_terms, .oe_terms,
  .array_feedback);

// ===== mra_board_model.sv
// Board logic resolving the I/O pin levels
`timescale 1ns/1ps
module mra_board_model (
  input wire logic [9:0] io_out,
  input wire logic [9:0] io_oe,
  input wire logic [9:0] drive,
  output logic [9:0] io_in
);
  assign io_in = (io_out & io_oe) | (drive & ~io_oe);
endmodule : mra_board_model

// ===== tb.sv
// Self-checking bench for the macrocell register array
`timescale 1ns/1ps
module tb;
  logic clk_sys = 0, nrst = 0, oe_pin_n = 1, preload_n = 1, en = 1;
  logic [9:0] in_pins = 0, pol = 0, ct = 0, rt = 0, pt = 0, ot = 0, brd = 0, ff = 0, prv = 0;
  logic [9:0] ex, io_in, io_out, io_oe, ai, aio, afb;
  logic [39:0] dt = 0;
  logic [31:0] s = 32'h0000_fbec;
  int err_total = 0;
  int comparisons = 0;
  mra_macrocell_register_array mra_macrocell_register_array_inst (.clk_sys, .nrst,
    .clk_en(en), .in_pins, .io_in, .io_out, .io_oe, .oe_pin_n, .preload_n,
    .data_terms(dt), .polarity_bits(pol), .clock_terms(ct), .reset_terms(rt),
    .preset_terms(pt), .oe_terms(ot), .array_inputs(ai), .array_io(aio), .array_feedback(afb));
  mra_board_model mra_board_model_inst (.io_out, .io_oe, .drive(brd), .io_in);
  initial forever #4 clk_sys = ~clk_sys;
  function automatic logic [9:0] xs();
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s[9:0];
  endfunction : xs
  // Expected pin level of a combinatorial cell
  function automatic logic q(input int i);
    return (|dt[4*i+:4]) ^ ~pol[i];
  endfunction : q
  task automatic step();
    @(posedge clk_sys);
    if (en)
    begin
      for (int i = 0; i < 10; i++)
        if (rt[i] && pt[i]) ex[i] = q(i);
        else
        begin
          ff[i] = rt[i] ? 1'b0 : pt[i] ? 1'b1 : (ct[i] && !prv[i]) ? ~q(i) : ff[i];
          ex[i] = ~ff[i];
        end
      prv = ct;
    end
    #1;
  endtask : step
  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
      err_total++;
    end
  endtask : chk
  task automatic test_done();
    $display("errors %0d of %0d checks", err_total, comparisons);
    if (err_total == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : test_done
  initial
  begin
    repeat (5) @(posedge clk_sys);
    #1 nrst = 1;
    oe_pin_n = 0;
    repeat (10) step();
    chk(io_out, 10'h3ff);
    repeat (400)
    begin
      dt = {xs(), xs(), xs(), xs()};
      {pol, ct, rt, pt, ot, in_pins, brd} = {xs(), xs(), xs() & xs(), xs() & xs(),
        xs(), xs(), xs()};
      step();
      chk(io_out, ex);
      chk(io_oe, ot);
    end
    // Clock enable low must freeze state despite an active reset term
    en = 0;
    rt = '1;
    repeat (3) step();
    chk(io_out, ex);
    chk(io_oe, ot);
    en = 1;
    {ct, rt, pt} = '0;
    step();
    preload_n = 0;
    repeat (10) step();
    ff = (ff & ot) | (~brd & ~ot);
    chk(io_out, ~ff);
    chk(ai, in_pins);
    preload_n = 1;
    repeat (8) step();
    chk(io_out, ex);
    chk(aio, io_in);
    chk(afb, ff);
    oe_pin_n = 1;
    ot = '1;
    repeat (8) step();
    chk(io_oe, '0);
    test_done();
  end
  initial
  begin
    #100000;
    err_total++;
    test_done();
  end
endmodule : tb
